// ### core/pia_pause_res.sv
// pia_pause_res: resolves local and partner pause abilities into transmit and receive pause enables.
// assumes partner ability is valid once negotiation has completed; result is zero before that.
`timescale 1ns/1ps
module pia_pause_res
   import pia_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic an_done,
   input pia_pause_t local_ab,
   input pia_pause_t partner_ab,
   output pia_pause_res_t res
);

   pia_pause_res_t res_reg;
   pia_pause_res_t res_next;

   always_comb begin
      res_next = '0;
      if (an_done) begin
         if (local_ab.pause && partner_ab.pause) begin
            res_next.tx_pause = 1'b1;
            res_next.rx_pause = 1'b1;
         end else if (!local_ab.pause && local_ab.asym && partner_ab.pause && partner_ab.asym) begin
            res_next.tx_pause = 1'b1;
         end else if (local_ab.pause && local_ab.asym && !partner_ab.pause && partner_ab.asym) begin
            res_next.rx_pause = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         res_reg <= '0;
      end else begin
         res_reg <= res_next;
      end
   end

   assign res = res_reg;

endmodule : pia_pause_res

// ### core/pia_pkg.sv
// pia_pkg: constants, state types and carriers for the identifier and advertisement register block.
// assumes one 50 MHz clock with a synchronous active-high reset; no timescale here.
package pia_pkg;

   // management register addresses
   localparam logic [4:0] PIA_ADDR_STATUS = 5'h01;
   localparam logic [4:0] PIA_ADDR_IDENT_HIGH = 5'h02;
   localparam logic [4:0] PIA_ADDR_IDENT_LOW = 5'h03;
   localparam logic [4:0] PIA_ADDR_ADVERT = 5'h04;

   // advertisement register fields
   localparam int PIA_ADV_NEXT_PAGE = 15;
   localparam int PIA_ADV_RESERVED_HI = 14;
   localparam int PIA_ADV_REMOTE_FAULT = 13;
   localparam int PIA_ADV_RESERVED_LO = 12;
   localparam int PIA_ADV_ASYM_PAUSE = 11;
   localparam int PIA_ADV_PAUSE = 10;
   localparam int PIA_ADV_FOUR_PAIR = 9;
   localparam int PIA_ADV_STRAP_MSB = 8;
   localparam int PIA_ADV_STRAP_LSB = 5;
   localparam int PIA_ADV_SEL_MSB = 4;
   localparam int PIA_ADV_SEL_LSB = 0;
   localparam logic [15:0] PIA_ADV_RESET = 16'h0001;
   localparam logic [15:0] PIA_ADV_WR_MASK = 16'hbdff;
   localparam logic [15:0] PIA_ADV_RD_MASK = 16'hadff;

   // identifier register fields
   localparam int PIA_ID_UPPER_LSB = 10;
   localparam int PIA_ID_MODEL_LSB = 4;
   localparam int PIA_ID_REV_LSB = 0;

   // status register field
   localparam int PIA_STATUS_AN_DONE = 5;

   // pause resolution field position in the phy control register
   localparam int PIA_PAUSE_RES_LSB = 12;

   // management frame encodings and bit counts
   localparam logic [1:0] PIA_OP_READ = 2'b10;
   localparam logic [1:0] PIA_OP_WRITE = 2'b01;
   localparam logic [4:0] PIA_OP_LAST = 5'h01;
   localparam logic [4:0] PIA_ADDR_LAST = 5'h04;
   localparam logic [4:0] PIA_TA_LAST = 5'h01;
   localparam logic [4:0] PIA_DATA_LAST = 5'h0f;
   localparam int PIA_SYNC_W = 11;

   typedef enum logic [2:0] {
      PIA_IDLE,
      PIA_PRE,
      PIA_START,
      PIA_OPCODE,
      PIA_PHYAD,
      PIA_REGAD,
      PIA_TURN,
      PIA_DATA
   } pia_state_t;

   typedef struct packed {
      pia_state_t state;
      logic [4:0] cnt;
      logic [1:0] op;
      logic [4:0] phyad;
      logic [4:0] regad;
      logic [15:0] shift;
      logic hit;
      logic mdc_prev;
      logic mdio_out;
      logic mdio_oe;
      logic [15:0] advert;
      logic strap_pending;
   } pia_ctx_t;

   typedef struct packed {
      logic pause;
      logic asym;
   } pia_pause_t;

   typedef struct packed {
      logic tx_pause;
      logic rx_pause;
   } pia_pause_res_t;

endpackage : pia_pkg

// ### core/pia_regs.sv
// pia_regs: identifier and auto-negotiation advertisement registers behind a serial management slave.
// assumes mdc at no more than one eighth of clk; mdc, mdio and straps are asynchronous pins.
`timescale 1ns/1ps

// How it works
// - first identifier register returns vendor identifier bits three to eighteen.
// - second identifier register bits 15:10 carry vendor identifier bits nineteen to twenty-four.
// - second identifier register bits 9:4 hold the six-bit model number.
// - second identifier register bits 3:0 hold the four-bit model revision.
// - the held advertisement word is what negotiation sends to the partner.
// - bit 15 is read-write next page request, reset zero.
// - bit 14 ignores writes and reads zero.
// - bit 13 is read-write remote fault advertisement, reset zero.
// - bit 12 is read-write, resets zero, reads zero; software writes zero.
// - bit 11 is read-write asymmetric pause ability, reset zero.
// - bit 10 is read-write symmetric pause ability, reset zero.
// - pause resolution outcome reported in phy control register bits 13:12.
// - bit 9 four-pair ability is permanently zero.
// - bits 8:5 are read-write technology abilities reset from straps.
// - bits 4:0 are read-write selector resetting to the 802.3u code.
// - status register bit 5 reads one once negotiation has completed.
module pia_regs
   import pia_pkg::*;
#(
   // arbitrary identity values
   parameter logic [15:0] VENDOR_ID_UPPER = 16'h1234,
   parameter logic [5:0] VENDOR_ID_LOWER = 6'h15,
   parameter logic [5:0] MODEL_NUMBER = 6'h2a,
   parameter logic [3:0] MODEL_REVISION = 4'h3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic [3:0] strap_ability,
   input wire logic [4:0] strap_phy_addr,
   input wire logic an_complete,
   input wire logic [15:0] partner_ability,
   output logic [15:0] advert_word,
   output logic [1:0] phy_control_pause_res
);

   pia_ctx_t cur_reg;
   pia_ctx_t cur_next;

   logic [PIA_SYNC_W-1:0] pins_raw;
   logic [PIA_SYNC_W-1:0] pins_sync;
   logic mdc_s;
   logic mdio_s;
   logic [3:0] strap_s;
   logic [4:0] phy_addr_s;
   logic mdc_rise;
   logic [4:0] phyad_full;
   logic [4:0] regad_full;
   logic [15:0] write_word;
   logic addr_hit;
   pia_pause_t local_ab;
   pia_pause_t partner_ab;
   pia_pause_res_t pause_res;

   assign pins_raw = {mdc, mdio_i, strap_ability, strap_phy_addr};

   pia_sync #(
      .W(PIA_SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   assign mdc_s = pins_sync[10];
   assign mdio_s = pins_sync[9];
   assign strap_s = pins_sync[8:5];
   assign phy_addr_s = pins_sync[4:0];

   assign mdc_rise = mdc_s && !cur_reg.mdc_prev;
   assign phyad_full = {cur_reg.phyad[3:0], mdio_s};
   assign regad_full = {cur_reg.regad[3:0], mdio_s};
   assign write_word = {cur_reg.shift[14:0], mdio_s};
   assign addr_hit = (cur_reg.phyad == phy_addr_s);

   // register read decode; unmapped addresses read zero
   function automatic logic [15:0] pia_read_word(
      input logic [4:0] addr,
      input logic [15:0] adv,
      input logic an_done
   );
      logic [15:0] word;
      word = '0;
      unique case (addr)
         PIA_ADDR_STATUS: begin
            word[PIA_STATUS_AN_DONE] = an_done;
         end
         PIA_ADDR_IDENT_HIGH: begin
            word = VENDOR_ID_UPPER;
         end
         PIA_ADDR_IDENT_LOW: begin
            word[15:PIA_ID_UPPER_LSB] = VENDOR_ID_LOWER;
            word[9:PIA_ID_MODEL_LSB] = MODEL_NUMBER;
            word[3:PIA_ID_REV_LSB] = MODEL_REVISION;
         end
         PIA_ADDR_ADVERT: begin
            word = adv & PIA_ADV_RD_MASK;
         end
         default: begin
            word = '0;
         end
      endcase
      return word;
   endfunction : pia_read_word

   always_comb begin
      cur_next = cur_reg;
      cur_next.mdc_prev = mdc_s;

      // straps settle through the synchroniser, then seed the ability bits once
      if (cur_reg.strap_pending) begin
         cur_next.advert[PIA_ADV_STRAP_MSB:PIA_ADV_STRAP_LSB] = strap_s;
         cur_next.strap_pending = 1'b0;
      end

      if (mdc_rise) begin
         unique case (cur_reg.state)
            PIA_IDLE: begin
               if (mdio_s) begin
                  cur_next.state = PIA_PRE;
               end
            end
            PIA_PRE: begin
               // any run of ones counts as preamble, so suppressed preambles work
               if (!mdio_s) begin
                  cur_next.state = PIA_START;
               end
            end
            PIA_START: begin
               cur_next.cnt = '0;
               if (mdio_s) begin
                  cur_next.state = PIA_OPCODE;
               end else begin
                  cur_next.state = PIA_IDLE;
               end
            end
            PIA_OPCODE: begin
               cur_next.op = {cur_reg.op[0], mdio_s};
               if (cur_reg.cnt == PIA_OP_LAST) begin
                  cur_next.cnt = '0;
                  cur_next.state = PIA_PHYAD;
               end else begin
                  cur_next.cnt = cur_reg.cnt + 5'h01;
               end
            end
            PIA_PHYAD: begin
               cur_next.phyad = phyad_full;
               if (cur_reg.cnt == PIA_ADDR_LAST) begin
                  cur_next.cnt = '0;
                  cur_next.state = PIA_REGAD;
               end else begin
                  cur_next.cnt = cur_reg.cnt + 5'h01;
               end
            end
            PIA_REGAD: begin
               cur_next.regad = regad_full;
               if (cur_reg.cnt == PIA_ADDR_LAST) begin
                  cur_next.cnt = '0;
                  cur_next.state = PIA_TURN;
                  cur_next.hit = addr_hit && (cur_reg.op == PIA_OP_READ || cur_reg.op == PIA_OP_WRITE);
                  cur_next.shift = pia_read_word(regad_full, cur_reg.advert, an_complete);
               end else begin
                  cur_next.cnt = cur_reg.cnt + 5'h01;
               end
            end
            PIA_TURN: begin
               if (cur_reg.cnt == PIA_TA_LAST) begin
                  cur_next.cnt = '0;
                  cur_next.state = PIA_DATA;
                  if (cur_reg.hit && cur_reg.op == PIA_OP_READ) begin
                     cur_next.mdio_out = cur_reg.shift[15];
                     cur_next.shift = {cur_reg.shift[14:0], 1'b0};
                  end else begin
                     cur_next.shift = '0;
                  end
               end else begin
                  cur_next.cnt = cur_reg.cnt + 5'h01;
                  // first turnaround bit stays undriven, the second is driven low
                  if (cur_reg.hit && cur_reg.op == PIA_OP_READ) begin
                     cur_next.mdio_oe = 1'b1;
                     cur_next.mdio_out = 1'b0;
                  end
               end
            end
            PIA_DATA: begin
               if (cur_reg.op == PIA_OP_READ) begin
                  cur_next.mdio_out = cur_reg.shift[15];
                  cur_next.shift = {cur_reg.shift[14:0], 1'b0};
               end else begin
                  cur_next.shift = write_word;
               end
               if (cur_reg.cnt == PIA_DATA_LAST) begin
                  cur_next.cnt = '0;
                  cur_next.state = PIA_IDLE;
                  cur_next.mdio_oe = 1'b0;
                  cur_next.mdio_out = 1'b0;
                  cur_next.hit = 1'b0;
                  if (cur_reg.hit && cur_reg.op == PIA_OP_WRITE && cur_reg.regad == PIA_ADDR_ADVERT) begin
                     // read-only bits keep their value; bit 12 is stored but masked on read
                     cur_next.advert = (write_word & PIA_ADV_WR_MASK)
                                     | (cur_reg.advert & ~PIA_ADV_WR_MASK);
                  end
                  // identifier addresses fall through here with no store
               end else begin
                  cur_next.cnt = cur_reg.cnt + 5'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_reg.state <= PIA_IDLE;
         cur_reg.cnt <= '0;
         cur_reg.op <= '0;
         cur_reg.phyad <= '0;
         cur_reg.regad <= '0;
         cur_reg.shift <= '0;
         cur_reg.hit <= 1'b0;
         cur_reg.mdc_prev <= 1'b0;
         cur_reg.mdio_out <= 1'b0;
         cur_reg.mdio_oe <= 1'b0;
         cur_reg.advert <= PIA_ADV_RESET;
         cur_reg.strap_pending <= 1'b1;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ability word handed to the negotiation engine
   assign advert_word = cur_reg.advert;

   assign local_ab.pause = cur_reg.advert[PIA_ADV_PAUSE];
   assign local_ab.asym = cur_reg.advert[PIA_ADV_ASYM_PAUSE];
   assign partner_ab.pause = partner_ability[PIA_ADV_PAUSE];
   assign partner_ab.asym = partner_ability[PIA_ADV_ASYM_PAUSE];

   pia_pause_res u_pause (
      .clk(clk),
      .rst(rst),
      .an_done(an_complete),
      .local_ab(local_ab),
      .partner_ab(partner_ab),
      .res(pause_res)
   );

   assign phy_control_pause_res = {pause_res.tx_pause, pause_res.rx_pause};

   assign mdio_o = cur_reg.mdio_out;
   assign mdio_oe = cur_reg.mdio_oe;

endmodule : pia_regs

// ### core/pia_sync.sv
// pia_sync: two-stage synchroniser for a bundle of slow pins.
// assumes every bit is independent or quasi-static, so per-bit skew is harmless.
`timescale 1ns/1ps
module pia_sync
   import pia_pkg::*;
#(
   parameter int W = PIA_SYNC_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } pia_sync_t;

   pia_sync_t sync_reg;
   pia_sync_t sync_next;

   always_comb begin
      sync_next.stage1 = async_in;
      sync_next.stage2 = sync_reg.stage1;
   end

   // no reset: pins keep flowing through reset, so straps are settled when it releases
   always_ff @(posedge clk) begin
      sync_reg <= sync_next;
   end

   assign sync_out = sync_reg.stage2;

endmodule : pia_sync

// ### dv/pia_chk.sv
// pia_chk: port-level assertions for pia_regs, bound to every instance.
// assumes single clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module pia_chk
   import pia_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe,
   input wire logic [3:0] strap_ability,
   input wire logic [4:0] strap_phy_addr,
   input wire logic an_complete,
   input wire logic [15:0] partner_ability,
   input wire logic [15:0] advert_word,
   input wire logic [1:0] phy_control_pause_res
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // l and p are {asym, pause}
   function automatic logic [1:0] pres(logic d, logic [1:0] l, logic [1:0] p);
      if (!d) return 2'b00;
      if (l[0] && p[0]) return 2'b11;
      if (l == 2'b10 && p == 2'b11) return 2'b10;
      if (l == 2'b11 && p == 2'b10) return 2'b01;
      return 2'b00;
   endfunction : pres

   reset_vals_a: assert property (@(posedge clk) disable iff (1'b0) rst |=>
      (advert_word == PIA_ADV_RESET && !mdio_oe && phy_control_pause_res == 2'b00)) else $error("reset values wrong");
   strap_load_a: assert property ($fell(rst) |-> ##2
      (advert_word == {7'h00, $past(strap_ability, 4), 5'h01})) else $error("strap load wrong");
   bit14_zero_a: assert property (advert_word[14] == 1'b0) else $error("bit 14 set");
   bit9_zero_a: assert property (advert_word[9] == 1'b0) else $error("bit 9 set");
   pause_res_a: assert property (1'b1 |=> phy_control_pause_res ==
      pres($past(an_complete), $past(advert_word[11:10]), $past(partner_ability[11:10])))
      else $error("pause resolution wrong");
   turn_low_a: assert property ($rose(mdio_oe) |-> (mdio_oe && !mdio_o) [*8]) else $error("turnaround wrong");
   oe_quiet_a: assert property ($changed(advert_word) |-> !mdio_oe) else $error("advert changed on read");
   idle_pause_a: assert property (!an_complete |=> phy_control_pause_res == 2'b00) else $error("pause early");

   read_c: cover property ($rose(mdio_oe));
   pause_c: cover property (phy_control_pause_res == 2'b11);
   write_c: cover property ($changed(advert_word));
endmodule : pia_chk

bind pia_regs pia_chk chk_u (.clk, .rst, .mdc, .mdio_i, .mdio_o, .mdio_oe, .strap_ability, .strap_phy_addr,
   .an_complete, .partner_ability, .advert_word, .phy_control_pause_res);

// ### dv/pia_station.sv
// pia_station: management station model driving mdc and its share of mdio.
// assumes the bench resolves the mdio wire with a pull-up; mdc idles low between frames.
`timescale 1ns/1ps
module pia_station
   import pia_pkg::*;
(
   input wire logic clk,
   input wire logic mdio,
   output logic mdc,
   output logic st_o,
   output logic st_oe
);
   initial begin
      mdc = 1'b0;
      st_o = 1'b1;
      st_oe = 1'b0;
   end

   // 32 preamble ones, start, opcode, addresses, turnaround, 16 data bits; mdc period 10 clk
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] bits;
      logic wr;
      wr = (op != PIA_OP_READ);
      bits = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         @(posedge clk);
         mdc <= 1'b0;
         st_o <= bits[i];
         st_oe <= wr || (i > 17);
         repeat (5) @(posedge clk);
         mdc <= 1'b1;
         if (i < 16) rd[i] = mdio;
         repeat (4) @(posedge clk);
      end
      @(posedge clk);
      mdc <= 1'b0;
      st_oe <= 1'b0;
   endtask : frame
endmodule : pia_station

// ### dv/tb_top.sv
// tb_top: self-checking bench for pia_regs with a management station model.
// assumes pia_pkg, pia_regs, pia_station and pia_chk are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_top
   import pia_pkg::*;
;
   // arbitrary identity values
   localparam logic [15:0] ID_HI = 16'h5a3c;
   localparam logic [5:0] ID_LO = 6'h2d;
   localparam logic [5:0] ID_MDL = 6'h19;
   localparam logic [3:0] ID_REV = 4'h6;
   logic clk, rst, mdio_i, mdio_o, mdio_oe, an_complete, mdc, st_o, st_oe;
   logic [3:0] strap_ability;
   logic [4:0] strap_phy_addr;
   logic [15:0] partner_ability, advert_word, exp_adv, rd;
   logic [1:0] phy_control_pause_res;
   logic [31:0] r;
   logic [31:0] seed = 32'h000173f6;
   int err_count = 0;
   int num_checks = 0;

   // wire level: device, then station, else pull-up
   assign mdio_i = mdio_oe ? mdio_o : (st_oe ? st_o : 1'b1);

   pia_regs #(.VENDOR_ID_UPPER(ID_HI), .VENDOR_ID_LOWER(ID_LO), .MODEL_NUMBER(ID_MDL), .MODEL_REVISION(ID_REV))
   dut_u (.clk(clk), .rst(rst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .strap_ability(strap_ability), .strap_phy_addr(strap_phy_addr), .an_complete(an_complete),
      .partner_ability(partner_ability), .advert_word(advert_word), .phy_control_pause_res(phy_control_pause_res));

   pia_station st_u (.clk(clk), .mdio(mdio_i), .mdc(mdc), .st_o(st_o), .st_oe(st_oe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [1:0] pres(logic d, logic [1:0] l, logic [1:0] p);
      if (!d) return 2'b00;
      if (l[0] && p[0]) return 2'b11;
      if (l == 2'b10 && p == 2'b11) return 2'b10;
      if (l == 2'b11 && p == 2'b10) return 2'b01;
      return 2'b00;
   endfunction : pres

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test

   task automatic acc(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
      st_u.frame(op, pa, ra, wd, rd);
      repeat (6) @(posedge clk);
      #1;
   endtask : acc

   task automatic wr_adv(input logic [15:0] wd);
      acc(PIA_OP_WRITE, strap_phy_addr, PIA_ADDR_ADVERT, wd);
      exp_adv = wd & PIA_ADV_WR_MASK;
      `CHK(advert_word, exp_adv)
      acc(PIA_OP_READ, strap_phy_addr, PIA_ADDR_ADVERT, 16'h0000);
      `CHK(rd, exp_adv & PIA_ADV_RD_MASK)
   endtask : wr_adv

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      $display("FAIL %0t watchdog expired", $time);
      stop_test();
   end

   initial begin
      rst = 1'b1;
      an_complete = 1'b0;
      partner_ability = 16'h0000;
      r = rnd();
      strap_ability = r[3:0];
      strap_phy_addr = r[8:4];
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      exp_adv = {7'h00, strap_ability, 5'h01};
      `CHK(advert_word, exp_adv)
      acc(PIA_OP_READ, strap_phy_addr, PIA_ADDR_ADVERT, 16'h0000);
      `CHK(rd, exp_adv & PIA_ADV_RD_MASK)
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         acc(PIA_OP_READ, strap_phy_addr, PIA_ADDR_IDENT_HIGH, 16'h0000);
         `CHK(rd, ID_HI)
         acc(PIA_OP_READ, strap_phy_addr, PIA_ADDR_IDENT_LOW, 16'h0000);
         `CHK(rd[15:10], ID_LO)
         `CHK(rd[9:4], ID_MDL)
         `CHK(rd[3:0], ID_REV)
         r = rnd();
         acc(PIA_OP_WRITE, strap_phy_addr, PIA_ADDR_IDENT_HIGH, r[15:0]);
         acc(PIA_OP_WRITE, strap_phy_addr, PIA_ADDR_IDENT_LOW, r[31:16]);
      end
      for (int k = 0; k < 2; k++) begin
         an_complete <= k[0];
         acc(PIA_OP_READ, strap_phy_addr, PIA_ADDR_STATUS, 16'h0000);
         `CHK(rd, {10'h000, k[0], 5'h00})
      end
      $display("test ident and status done");
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         if (k == 0) r[15:0] = 16'hefff;
         if (k == 1) r[15:0] = 16'h0000;
         wr_adv(r[15:0] & 16'hefff);
      end
      r = rnd();
      acc(PIA_OP_WRITE, strap_phy_addr ^ 5'h01, PIA_ADDR_ADVERT, r[15:0] & 16'hefff);
      acc(2'b00, strap_phy_addr, PIA_ADDR_ADVERT, r[31:16] & 16'hefff);
      acc(2'b11, strap_phy_addr, PIA_ADDR_ADVERT, r[15:0] & 16'hefff);
      `CHK(advert_word, exp_adv)
      acc(PIA_OP_READ, strap_phy_addr ^ 5'h01, PIA_ADDR_ADVERT, 16'h0000);
      `CHK(rd, 16'hffff)
      acc(PIA_OP_READ, strap_phy_addr, 5'h1f, 16'h0000);
      `CHK(rd, 16'h0000)
      $display("test advertise done");
      for (int l = 0; l < 4; l++) begin
         r = rnd();
         an_complete <= 1'b0;
         wr_adv({r[15:12], l[1:0], r[9:0]} & 16'hefff);
         for (int p = 0; p < 4; p++) begin
            r = rnd();
            partner_ability <= {r[15:12], p[1:0], r[9:0]};
            an_complete <= r[16] | p[0];
            repeat (3) @(posedge clk);
            #1;
            `CHK(phy_control_pause_res, pres(an_complete, l[1:0], p[1:0]))
         end
      end
      $display("test pause done");
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK(advert_word, {7'h00, strap_ability, 5'h01})
      $display("test second reset done");
      stop_test();
   end
endmodule : tb_top
